/* File: battery_monitor_pkg.sv */
// Constants and carrier types for the battery monitor two-wire slave
package battery_monitor_pkg;
	localparam logic [6:0] DEVICE_BUS_ADDRESS = 7'h36;
	localparam logic [7:0] ADDR_STATUS        = 8'h01;
	localparam logic [7:0] ADDR_AUX0_HI       = 8'h08;
	localparam logic [7:0] ADDR_AUX0_LO       = 8'h09;
	localparam logic [7:0] ADDR_AUX1_HI       = 8'h0a;
	localparam logic [7:0] ADDR_AUX1_LO       = 8'h0b;
	localparam logic [7:0] ADDR_VOLTS_HI      = 8'h0c;
	localparam logic [7:0] ADDR_VOLTS_LO      = 8'h0d;
	localparam logic [7:0] ADDR_CURRENT_HI    = 8'h0e;
	localparam logic [7:0] ADDR_CURRENT_LO    = 8'h0f;
	localparam logic [7:0] ADDR_CHARGE_HI     = 8'h10;
	localparam logic [7:0] ADDR_CHARGE_LO     = 8'h11;
	localparam logic [7:0] ADDR_CURRENT_TRIM  = 8'h61;
	localparam logic [7:0] ADDR_ACCUM_TRIM    = 8'h62;
	localparam logic [7:0] PTR_STEP           = 8'h01;
	localparam logic [7:0] RESERVED_READ      = 8'h00;
	localparam logic [7:0] RST_BYTE           = 8'h00;
	localparam logic [3:0] BYTE_BITS          = 4'h8;
	localparam int         POWER_UP_BIT       = 6;
	localparam int         SLEEP_BIT          = 5;
	localparam int         BLANK_BIT          = 4;
	localparam int         DRIVE_OFF_BIT      = 3;
	localparam int         AUX1_VALID_BIT     = 1;
	localparam int         AUX0_VALID_BIT     = 0;
	localparam logic       RST_POWER_UP       = 1'b1;
	localparam logic       RST_SLEEP_ALLOW    = 1'b1;
	localparam logic       RST_BLANK          = 1'b1;
	localparam logic       RST_DRIVE_OFF      = 1'b0;

	typedef struct packed {
		logic [15:0] aux0;
		logic [15:0] aux1;
		logic [15:0] volts;
		logic [15:0] current;
		logic [15:0] charge;
		logic        aux1_valid;
		logic        aux0_valid;
	} meas_t;

	typedef struct packed {
		logic       sleep_allow;
		logic       discharge_blank_enable;
		logic       divider_drive_off;
		logic [7:0] current_trim;
		logic [7:0] accumulate_trim;
	} cfg_t;

	typedef enum logic [4:0] {
		st_idle  = 5'b00001,
		st_addr  = 5'b00010,
		st_ptr   = 5'b00100,
		st_wdata = 5'b01000,
		st_rdata = 5'b10000
	} link_state_t;
endpackage : battery_monitor_pkg

/* File: battery_monitor_twowire_regs.sv */
// Two-wire slave and register map of the battery monitor
// What this block does
// - Upper byte read latches pair for command
// - Addresses 08-0F read-only results, reset zero
// - Charge accumulator at 10/11, read-write
// - Power-up flag set at reset, write-zero clears
// - Sleep-allow bit defaults one, gates sleep
// - Blank-enable bit defaults one, controls blanking
// - Divider-drive-off bit zero lets divider drive
// - Status bits 1,0 report aux valid
// - Slave only, never starts, up to 400kHz
// - Sample data as input, return open drain
// - Data stable while clock high
// - Data edges during clock high mark start/stop
// - Stop idles bus, repeated start restarts
// - Receiver pulls data low on ninth clock
// - Eight bits msb first, then acknowledge
// - Upper byte even address, lower next odd
// - Match fixed address, acknowledge, else silent
// - Direction bit zero writes, one reads
// - First write byte sets register pointer
// - Pointer advances after every data byte
// - Discard writes to read-only or reserved
`timescale 1ns/1ps
module battery_monitor_twowire_regs
(
	input  wire logic                       i_core_clk,
	input  wire logic                       i_rst_b,
	input  wire logic                       i_link_clk,
	input  wire logic                       i_scl,
	input  wire logic                       i_sda,
	output logic                            o_sda,
	output logic                            o_sda_oe,
	input  wire battery_monitor_pkg::meas_t i_meas,
	input  wire logic                       i_meas_load,
	output logic                            o_meas_ready,
	output battery_monitor_pkg::cfg_t       o_cfg,
	output logic                            o_charge_write,
	output logic [15:0]                     o_charge_value
);

	// Link-domain reset: asserted asynchronously, released on the link clock
	logic rst_m;
	logic link_rst_b;
	always_ff @(posedge i_link_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_m      <= 1'b0;
			link_rst_b <= 1'b0;
		end
		else
		begin
			rst_m      <= 1'b1;
			link_rst_b <= rst_m;
		end
	end

	// Bus pin synchronisers; the third stage only feeds edge detection
	logic scl_m, scl_s, scl_p;
	logic sda_m, sda_s, sda_p;
	always_ff @(posedge i_link_clk or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
		end
		else
		begin
			{scl_m, scl_s, scl_p} <= {i_scl, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {i_sda, sda_m, sda_s};
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = scl_s & ~scl_p;
	assign scl_fall  = ~scl_s & scl_p;
	assign start_det = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

	battery_monitor_pkg::link_state_t state;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg;
	logic        in_ack;
	logic        rd_mode;
	logic        master_nack;
	logic        sda_oe;
	logic [7:0]  pointer;
	logic [7:0]  hold_lo;
	logic [7:0]  hold_addr;
	logic        hold_valid;
	battery_monitor_pkg::meas_t res;
	battery_monitor_pkg::cfg_t  cfg;
	logic        power_up_flag;
	logic [15:0] charge_word;
	logic        cfg_tgl;
	logic        chg_tgl;
	logic        meas_ack;
	logic [7:0]  status_byte;

	// Core-to-link measurement handshake signals
	logic                       meas_tgl;
	battery_monitor_pkg::meas_t meas_hold;
	logic                       meas_m, meas_s;
	logic                       meas_take;

	always_comb
	begin
		status_byte = battery_monitor_pkg::RST_BYTE;
		status_byte[battery_monitor_pkg::POWER_UP_BIT]   = power_up_flag;
		status_byte[battery_monitor_pkg::SLEEP_BIT]      = cfg.sleep_allow;
		status_byte[battery_monitor_pkg::BLANK_BIT]      = cfg.discharge_blank_enable;
		status_byte[battery_monitor_pkg::DRIVE_OFF_BIT]  = cfg.divider_drive_off;
		status_byte[battery_monitor_pkg::AUX1_VALID_BIT] = res.aux1_valid;
		status_byte[battery_monitor_pkg::AUX0_VALID_BIT] = res.aux0_valid;
	end

	function automatic logic [7:0] read_byte(input logic [7:0] a);
		case (a)
			battery_monitor_pkg::ADDR_STATUS:       read_byte = status_byte;
			battery_monitor_pkg::ADDR_AUX0_HI:      read_byte = res.aux0[15:8];
			battery_monitor_pkg::ADDR_AUX0_LO:      read_byte = res.aux0[7:0];
			battery_monitor_pkg::ADDR_AUX1_HI:      read_byte = res.aux1[15:8];
			battery_monitor_pkg::ADDR_AUX1_LO:      read_byte = res.aux1[7:0];
			battery_monitor_pkg::ADDR_VOLTS_HI:     read_byte = res.volts[15:8];
			battery_monitor_pkg::ADDR_VOLTS_LO:     read_byte = res.volts[7:0];
			battery_monitor_pkg::ADDR_CURRENT_HI:   read_byte = res.current[15:8];
			battery_monitor_pkg::ADDR_CURRENT_LO:   read_byte = res.current[7:0];
			battery_monitor_pkg::ADDR_CHARGE_HI:    read_byte = res.charge[15:8];
			battery_monitor_pkg::ADDR_CHARGE_LO:    read_byte = res.charge[7:0];
			battery_monitor_pkg::ADDR_CURRENT_TRIM: read_byte = cfg.current_trim;
			battery_monitor_pkg::ADDR_ACCUM_TRIM:   read_byte = cfg.accumulate_trim;
			default:                                read_byte = battery_monitor_pkg::RESERVED_READ;
		endcase
	endfunction : read_byte

	// Upper halves sit at even addresses, the lower half one above
	function automatic logic is_pair_hi(input logic [7:0] a);
		is_pair_hi = (a == battery_monitor_pkg::ADDR_AUX0_HI) ||
			(a == battery_monitor_pkg::ADDR_AUX1_HI) ||
			(a == battery_monitor_pkg::ADDR_VOLTS_HI) ||
			(a == battery_monitor_pkg::ADDR_CURRENT_HI) ||
			(a == battery_monitor_pkg::ADDR_CHARGE_HI);
	endfunction : is_pair_hi

	logic [7:0] next_byte;
	logic       byte_done;
	logic       wr_en;
	logic       addr_match;
	// A process, not an assign, so result updates behind the function are seen
	always_comb
		next_byte = (hold_valid && pointer == hold_addr) ? hold_lo : read_byte(pointer);
	assign byte_done = scl_fall && !in_ack && bit_cnt == battery_monitor_pkg::BYTE_BITS;
	assign wr_en      = byte_done && state == battery_monitor_pkg::st_wdata;
	assign addr_match = shreg[7:1] == battery_monitor_pkg::DEVICE_BUS_ADDRESS;

	// Bus protocol engine; only ever answers, never originates a transfer
	always_ff @(posedge i_link_clk or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			state       <= battery_monitor_pkg::st_idle;
			bit_cnt     <= '0;
			shreg       <= '0;
			in_ack      <= 1'b0;
			rd_mode     <= 1'b0;
			master_nack <= 1'b0;
			sda_oe      <= 1'b0;
			pointer     <= '0;
			hold_lo     <= '0;
			hold_addr   <= '0;
			hold_valid  <= 1'b0;
		end
		else if (start_det)
		begin
			state      <= battery_monitor_pkg::st_addr;
			bit_cnt    <= '0;
			in_ack     <= 1'b0;
			sda_oe     <= 1'b0;
			hold_valid <= 1'b0;
		end
		else if (stop_det)
		begin
			state      <= battery_monitor_pkg::st_idle;
			in_ack     <= 1'b0;
			sda_oe     <= 1'b0;
			hold_valid <= 1'b0;
		end
		else if (state != battery_monitor_pkg::st_idle)
		begin
			if (scl_rise)
			begin
				if (in_ack)
					master_nack <= sda_s;
				else
				begin
					shreg   <= {shreg[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end
			end
			else if (scl_fall && in_ack)
			begin
				in_ack  <= 1'b0;
				bit_cnt <= '0;
				sda_oe  <= 1'b0;
				unique case (state)
					battery_monitor_pkg::st_idle: ;
					battery_monitor_pkg::st_addr:
						state <= rd_mode ? battery_monitor_pkg::st_rdata
							: battery_monitor_pkg::st_ptr;
					battery_monitor_pkg::st_ptr: state <= battery_monitor_pkg::st_wdata;
					battery_monitor_pkg::st_wdata: ;
					battery_monitor_pkg::st_rdata:
						if (master_nack)
							state <= battery_monitor_pkg::st_idle;
				endcase
				if ((state == battery_monitor_pkg::st_addr && rd_mode) ||
					(state == battery_monitor_pkg::st_rdata && !master_nack))
				begin
					shreg  <= next_byte;
					sda_oe <= ~next_byte[7];
					if (is_pair_hi(pointer))
					begin
						hold_lo    <= read_byte(pointer + battery_monitor_pkg::PTR_STEP);
						hold_addr  <= pointer + battery_monitor_pkg::PTR_STEP;
						hold_valid <= 1'b1;
					end
				end
			end
			else if (byte_done)
			begin
				unique case (state)
					battery_monitor_pkg::st_idle: ;
					battery_monitor_pkg::st_addr:
						if (addr_match)
						begin
							rd_mode <= shreg[0];
							in_ack  <= 1'b1;
							sda_oe  <= 1'b1;
						end
						else
							state <= battery_monitor_pkg::st_idle;
					battery_monitor_pkg::st_ptr:
					begin
						pointer <= shreg;
						in_ack  <= 1'b1;
						sda_oe  <= 1'b1;
					end
					battery_monitor_pkg::st_wdata:
					begin
						pointer <= pointer + battery_monitor_pkg::PTR_STEP;
						in_ack  <= 1'b1;
						sda_oe  <= 1'b1;
					end
					battery_monitor_pkg::st_rdata:
					begin
						pointer <= pointer + battery_monitor_pkg::PTR_STEP;
						in_ack  <= 1'b1;
						sda_oe  <= 1'b0;
					end
				endcase
			end
			else if (scl_fall && state == battery_monitor_pkg::st_rdata)
				sda_oe <= ~shreg[7];
		end
	end

	assign o_sda    = 1'b0;
	assign o_sda_oe = sda_oe;

	// Link-side register file; a bus write wins over a result update
	always_ff @(posedge i_link_clk or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			res                        <= '0;
			power_up_flag              <= battery_monitor_pkg::RST_POWER_UP;
			cfg.sleep_allow            <= battery_monitor_pkg::RST_SLEEP_ALLOW;
			cfg.discharge_blank_enable <= battery_monitor_pkg::RST_BLANK;
			cfg.divider_drive_off      <= battery_monitor_pkg::RST_DRIVE_OFF;
			cfg.current_trim           <= battery_monitor_pkg::RST_BYTE;
			cfg.accumulate_trim        <= battery_monitor_pkg::RST_BYTE;
			charge_word                <= '0;
			cfg_tgl                    <= 1'b0;
			chg_tgl                    <= 1'b0;
			meas_ack                   <= 1'b0;
			meas_m                     <= 1'b0;
			meas_s                     <= 1'b0;
		end
		else
		begin
			meas_m <= meas_tgl;
			meas_s <= meas_m;
			if (meas_take)
			begin
				res      <= meas_hold;
				meas_ack <= meas_s;
			end
			if (wr_en)
			begin
				case (pointer)
					battery_monitor_pkg::ADDR_STATUS:
					begin
						power_up_flag <= power_up_flag & shreg[battery_monitor_pkg::POWER_UP_BIT];
						cfg.sleep_allow            <= shreg[battery_monitor_pkg::SLEEP_BIT];
						cfg.discharge_blank_enable <= shreg[battery_monitor_pkg::BLANK_BIT];
						cfg.divider_drive_off      <= shreg[battery_monitor_pkg::DRIVE_OFF_BIT];
						cfg_tgl                    <= ~cfg_tgl;
					end
					battery_monitor_pkg::ADDR_CHARGE_HI:
					begin
						res.charge[15:8]  <= shreg;
						charge_word[15:8] <= shreg;
						chg_tgl           <= ~chg_tgl;
					end
					battery_monitor_pkg::ADDR_CHARGE_LO:
					begin
						res.charge[7:0]  <= shreg;
						charge_word[7:0] <= shreg;
						chg_tgl          <= ~chg_tgl;
					end
					battery_monitor_pkg::ADDR_CURRENT_TRIM:
					begin
						cfg.current_trim <= shreg;
						cfg_tgl          <= ~cfg_tgl;
					end
					battery_monitor_pkg::ADDR_ACCUM_TRIM:
					begin
						cfg.accumulate_trim <= shreg;
						cfg_tgl             <= ~cfg_tgl;
					end
					default: ;
				endcase
			end
		end
	end
	assign meas_take = meas_s != meas_ack;

	// Core side: measurement words are held until the link returns the toggle
	logic ack_m, ack_s;
	assign o_meas_ready = meas_tgl == ack_s;
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meas_tgl  <= 1'b0;
			meas_hold <= '0;
			ack_m     <= 1'b0;
			ack_s     <= 1'b0;
		end
		else
		begin
			ack_m <= meas_ack;
			ack_s <= ack_m;
			if (i_meas_load && o_meas_ready)
			begin
				meas_hold <= i_meas;
				meas_tgl  <= ~meas_tgl;
			end
		end
	end

	// Link words are quiet for a whole bus byte after a toggle, far longer than the sync
	logic cfg_m, cfg_s, cfg_p, chg_m, chg_s, chg_p;
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			{cfg_m, cfg_s, cfg_p}        <= 3'h0;
			{chg_m, chg_s, chg_p}        <= 3'h0;
			o_cfg.sleep_allow            <= battery_monitor_pkg::RST_SLEEP_ALLOW;
			o_cfg.discharge_blank_enable <= battery_monitor_pkg::RST_BLANK;
			o_cfg.divider_drive_off      <= battery_monitor_pkg::RST_DRIVE_OFF;
			o_cfg.current_trim           <= battery_monitor_pkg::RST_BYTE;
			o_cfg.accumulate_trim        <= battery_monitor_pkg::RST_BYTE;
			o_charge_write               <= 1'b0;
			o_charge_value               <= '0;
		end
		else
		begin
			{cfg_m, cfg_s, cfg_p} <= {cfg_tgl, cfg_m, cfg_s};
			{chg_m, chg_s, chg_p} <= {chg_tgl, chg_m, chg_s};
			if (cfg_s != cfg_p)
				o_cfg <= cfg;
			o_charge_write <= chg_s != chg_p;
			if (chg_s != chg_p)
				o_charge_value <= charge_word;
		end
	end

	a_addr_ack: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		byte_done && state == battery_monitor_pkg::st_addr && addr_match |=> sda_oe && in_ack)
		else $error("address match not acknowledged");

	a_addr_silent: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		byte_done && state == battery_monitor_pkg::st_addr && !addr_match
		|=> !sda_oe && state == battery_monitor_pkg::st_idle)
		else $error("foreign address answered");

	a_start_rearm: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		start_det |=> state == battery_monitor_pkg::st_addr && bit_cnt == 4'h0 && !sda_oe)
		else $error("start did not rearm address phase");

	a_stop_idle: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		stop_det |=> state == battery_monitor_pkg::st_idle && !sda_oe)
		else $error("stop did not idle the slave");

	a_ptr_advance: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		byte_done && (state == battery_monitor_pkg::st_wdata || state == battery_monitor_pkg::st_rdata)
		|=> pointer == $past(pointer) + battery_monitor_pkg::PTR_STEP)
		else $error("pointer did not advance");

	a_flag_cleared: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		$fell(power_up_flag) |-> $past(wr_en && pointer == battery_monitor_pkg::ADDR_STATUS
		&& !shreg[battery_monitor_pkg::POWER_UP_BIT]))
		else $error("power-up flag cleared without a zero write");

	a_sda_steady: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		$changed(sda_oe) |-> $past(scl_fall || start_det || stop_det))
		else $error("data driven while clock high");

	a_pair_hold: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		scl_fall && in_ack && state == battery_monitor_pkg::st_rdata && !master_nack
		&& hold_valid && pointer == hold_addr |=> shreg == $past(hold_lo))
		else $error("latched lower byte not served");

	a_ro_discard: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		wr_en && !meas_take && pointer >= battery_monitor_pkg::ADDR_AUX0_HI
		&& pointer <= battery_monitor_pkg::ADDR_CURRENT_LO |=> $stable(res) && $stable(cfg))
		else $error("read-only write changed a register");

	a_ack_release: assert property (@(posedge i_link_clk) disable iff (!link_rst_b)
		byte_done && state == battery_monitor_pkg::st_rdata |=> !sda_oe [*2])
		else $error("slave held data during master acknowledge");

endmodule : battery_monitor_twowire_regs

/* File: battery_monitor_twowire_regs_tb.sv */
// Self-checking bench for the battery monitor two-wire register block
`timescale 1ns/1ps
module battery_monitor_twowire_regs_tb;
	localparam logic [6:0] DEV = battery_monitor_pkg::DEVICE_BUS_ADDRESS;
	logic                       clk;
	logic                       lclk;
	logic                       rst_b;
	logic                       scl;
	logic                       m_low;
	logic                       sda;
	logic                       sda_oe;
	logic                       sda_val;
	logic                       load;
	logic                       ready;
	logic                       cw;
	logic [15:0]                cval;
	battery_monitor_pkg::meas_t meas;
	battery_monitor_pkg::meas_t m;
	battery_monitor_pkg::cfg_t  cfg;
	logic [7:0]                 rd [0:31];
	logic                       a;
	logic [31:0]                v;
	int                         seed;
	int                         failures;
	int                         check_count;
	int                         pulses = 0;
	int                         p0;

	// Pull-up wins unless some party pulls low
	assign sda = ~(sda_oe | m_low);

	battery_monitor_twowire_regs dut
	(
		.i_core_clk     (clk),
		.i_rst_b        (rst_b),
		.i_link_clk     (lclk),
		.i_scl          (scl),
		.i_sda          (sda),
		.o_sda          (sda_val),
		.o_sda_oe       (sda_oe),
		.i_meas         (meas),
		.i_meas_load    (load),
		.o_meas_ready   (ready),
		.o_cfg          (cfg),
		.o_charge_write (cw),
		.o_charge_value (cval)
	);

	twowire_master_model master
	(
		.o_scl     (scl),
		.o_sda_low (m_low),
		.i_sda     (sda)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		lclk = 1'b0;
		#3.7;
		forever #7.5 lclk = ~lclk;
	end

	always @(posedge clk)
		if (cw === 1'b1)
			pulses <= pulses + 1;

	task automatic fail(input string what);
		failures++;
		$display("[ERR] %0t %s", $time, what);
	endtask : fail

	task automatic check_bit(input logic g, input logic e, input string w);
		check_count++;
		if (g !== e)
			fail(w);
	endtask : check_bit

	task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string w);
		check_count++;
		if (g !== e)
			fail(w);
	endtask : check_byte

	task automatic check_word(input logic [15:0] g, input logic [15:0] e, input string w);
		check_count++;
		if (g !== e)
			fail(w);
	endtask : check_word

	task automatic wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	function automatic battery_monitor_pkg::meas_t rand_meas();
		logic [95:0] r;
		r = {$random(seed), $random(seed), $random(seed)};
		return r[81:0];
	endfunction : rand_meas

	// Status as a master should see it: reserved bits read zero
	function automatic logic [7:0] st_exp(input logic pf, input logic [2:0] c,
		input battery_monitor_pkg::meas_t x);
		return {1'b0, pf, c, 1'b0, x.aux1_valid, x.aux0_valid};
	endfunction : st_exp

	task automatic load_meas(input battery_monitor_pkg::meas_t x);
		int k;
		k = 0;
		@(negedge clk);
		while (ready !== 1'b1 && k < 50)
		begin
			@(negedge clk);
			k++;
		end
		check_bit(ready, 1'b1, "ready");
		@(posedge clk);
		meas <= x;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : load_meas

	task automatic bus_open(input logic [7:0] ptr);
		logic k;
		master.start_cond();
		master.write_byte({DEV, 1'b0}, k);
		check_bit(k, 1'b1, "addr ack");
		master.write_byte(ptr, k);
		check_bit(k, 1'b1, "ptr ack");
	endtask : bus_open

	task automatic bus_write(input logic [7:0] ptr, input logic [15:0] d, input int n);
		logic k;
		bus_open(ptr);
		for (int i = 0; i < n; i++)
		begin
			master.write_byte(d[15 - 8 * i -: 8], k);
			check_bit(k, 1'b1, "data ack");
		end
		master.stop_cond();
		repeat (10) @(posedge clk);
	endtask : bus_write

	// Pointer write, repeated start, then read; with fin set the final byte is refused and a stop follows
	task automatic bus_read(input logic [7:0] ptr, input int n, input logic fin);
		logic k;
		bus_open(ptr);
		master.start_cond();
		master.write_byte({DEV, 1'b1}, k);
		check_bit(k, 1'b1, "read ack");
		for (int i = 0; i < n; i++)
			master.read_byte(fin && i == n - 1, rd[i]);
		if (fin)
			master.stop_cond();
	endtask : bus_read

	initial
	begin
		seed = 22525;
		rst_b = 1'b0;
		load = 1'b0;
		meas = '0;
		failures = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		check_word({cfg.current_trim, cfg.accumulate_trim}, 16'h0000, "trim rst");
		check_bit(sda_val, 1'b0, "open drain");
		bus_read(8'h01, 17, 1'b1);
		check_byte(rd[0], 8'h70, "status rst");
		for (int i = 7; i < 15; i++)
			check_byte(rd[i], 8'h00, "result rst");
		master.start_cond();
		master.write_byte({DEV ^ 7'h01, 1'b0}, a);
		check_bit(a, 1'b0, "foreign addr");
		master.start_cond();
		master.write_byte({DEV, 1'b0}, a);
		check_bit(a, 1'b1, "retry ack");
		master.stop_cond();
		m = rand_meas();
		load_meas(m);
		bus_read(8'h01, 1, 1'b1);
		check_byte(rd[0], st_exp(1'b1, 3'b110, m), "valid bits");
		bus_read(8'h08, 10, 1'b1);
		for (int i = 0; i < 5; i++)
			check_word({rd[2 * i], rd[2 * i + 1]}, m[81 - 16 * i -: 16], "result");
		bus_write(8'h0c, {~m.volts[15:8], 8'h00}, 1);
		bus_read(8'h0c, 1, 1'b1);
		check_byte(rd[0], m.volts[15:8], "ro write");
		bus_write(8'h01, 16'h0000, 1);
		check_word({13'h0000, cfg.sleep_allow, cfg.discharge_blank_enable,
			cfg.divider_drive_off}, 16'h0000, "cfg zero");
		bus_read(8'h01, 1, 1'b1);
		check_byte(rd[0], st_exp(1'b0, 3'b000, m), "flag clear");
		bus_write(8'h01, 16'hff00, 1);
		check_bit(cfg.divider_drive_off, 1'b1, "drive off");
		bus_read(8'h01, 1, 1'b1);
		check_byte(rd[0], st_exp(1'b0, 3'b111, m), "flag kept");
		v = $random(seed);
		p0 = pulses;
		bus_write(8'h10, v[15:0], 2);
		check_byte(8'(pulses - p0), 8'h02, "charge pulses");
		check_word(cval, v[15:0], "charge port");
		bus_read(8'h10, 2, 1'b1);
		check_word({rd[0], rd[1]}, v[15:0], "charge rd");
		bus_write(8'h61, v[31:16], 2);
		check_word({cfg.current_trim, cfg.accumulate_trim}, v[31:16], "trim");
		bus_open(8'h61);
		for (int i = 0; i < 4; i++)
			master.put_bit(1'b0, a);
		master.stop_cond();
		bus_read(8'h61, 2, 1'b1);
		check_word({rd[0], rd[1]}, v[31:16], "partial byte");
		bus_read(8'h0e, 0, 1'b0);
		load_meas(rand_meas());
		master.read_byte(1'b0, rd[0]);
		master.read_byte(1'b1, rd[1]);
		master.stop_cond();
		check_word({rd[0], rd[1]}, m.current, "latched pair");
		m = meas;
		bus_read(8'h0e, 2, 1'b1);
		check_word({rd[0], rd[1]}, m.current, "new pair");
		wrap_up();
	end

	initial
	begin
		#2_400_000;
		fail("timeout");
		wrap_up();
	end
endmodule : battery_monitor_twowire_regs_tb

/* File: twowire_master_model.sv */
// Timed two-wire bus master model with an open-drain data driver
`timescale 1ns/1ps
module twowire_master_model
#(parameter int QTR = 625)
(
	output logic      o_scl,
	output logic      o_sda_low,
	input  wire logic i_sda
);
	initial
	begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Works from idle and, with the clock low, as a repeated start
	task automatic start_cond;
		o_sda_low = 1'b0;
		#QTR o_scl = 1'b1;
		#QTR o_sda_low = 1'b1;
		#QTR o_scl = 1'b0;
		#QTR;
	endtask : start_cond

	task automatic stop_cond;
		o_sda_low = 1'b1;
		#QTR o_scl = 1'b1;
		#QTR o_sda_low = 1'b0;
		#QTR;
	endtask : stop_cond

	// Data moves only while the clock is low; sampled mid-high
	task automatic put_bit(input logic bv, output logic seen);
		o_sda_low = ~bv;
		#QTR o_scl = 1'b1;
		#QTR seen = i_sda;
		#QTR o_scl = 1'b0;
		#QTR;
	endtask : put_bit

	task automatic write_byte(input logic [7:0] bt, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(bt[i], s);
		put_bit(1'b1, s);
		ack = ~s;
	endtask : write_byte

	// Last byte of a read is refused to hand the line back
	task automatic read_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(1'b1, d[i]);
		put_bit(last, s);
	endtask : read_byte
endmodule : twowire_master_model
